// [pkg/abp_pkg.sv]
// constants and carrier types for the byte-parallel converter host port
package abp_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  // output timings in ns and the cycle counts derived from them (times under one clock period round up to one cycle, longer ones round down)
  localparam int unsigned T_RD_TO_DONE_NS = 50;
  localparam int unsigned T_CS_OFF_NS = 60;
  localparam int unsigned T_RD_OFF_NS = 40;
  localparam int unsigned T_DONE_CYC = (T_RD_TO_DONE_NS / CLK_PERIOD_NS < 1) ? 1 :
    T_RD_TO_DONE_NS / CLK_PERIOD_NS;
  localparam int unsigned T_CS_OFF_CYC = (T_CS_OFF_NS / CLK_PERIOD_NS < 1) ? 1 :
    T_CS_OFF_NS / CLK_PERIOD_NS;
  localparam int unsigned T_RD_OFF_CYC = (T_RD_OFF_NS / CLK_PERIOD_NS < 1) ? 1 :
    T_RD_OFF_NS / CLK_PERIOD_NS;
  // conversion clock cycles for acquisition and conversion
  localparam logic [4:0] ACQ_CYCLES = 5'h03;
  localparam logic [4:0] CONV_CYCLES = 5'h0d;
  // configuration field positions
  localparam int unsigned CFG_ACQ_EXT_BIT = 5;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  localparam int unsigned RES_W = 10;
  localparam int unsigned BYTE_W = 8;

  typedef enum logic [1:0] {
    ABP_IDLE = 2'b00,
    ABP_ACQ = 2'b01,
    ABP_CONV = 2'b10,
    ABP_WAIT_EXT = 2'b11
  } abp_state_t;

  // host strobes after synchronising
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic hbsel;
  } abp_strobe_t;
endpackage : abp_pkg

// [src/abp_sync.sv]
// three-stage synchroniser with agreement filter for one host pin
`timescale 1ns/1ps
module abp_sync (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // pin and filtered level
  input wire logic pin_in,
  output logic level_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;
  logic level_nxt;

  // a change counts only once stages two and three agree
  always_comb
  begin
    level_nxt = level_r;
    if (s2_r == s3_r)
    begin
      level_nxt = s3_r;
    end
  end

  // reset every stage high, the inactive level of the active-low strobes
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      level_r <= 1'b1;
    end
    else
    begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_r <= level_nxt;
    end
  end

  assign level_out = level_r;
endmodule : abp_sync

// [src/abp_host_port.sv]
// byte-parallel host port: result readout, config write, conversion sequencing
`timescale 1ns/1ps
module abp_host_port (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // host strobes, all active low except the byte select
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic high_byte_select,
  // conversion clock from the outside, sampled as a level
  input wire logic conv_clk,
  // converter core result, valid at conversion end
  input wire logic [9:0] core_result,
  // shared data bus as three signals
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  // completion flag pin, three-state
  output logic conversion_done_n,
  output logic conversion_done_oe,
  // latched configuration and busy status
  output logic [7:0] config_byte,
  output logic converting
);
  abp_pkg::abp_strobe_t strb;
  abp_pkg::abp_strobe_t strb_d_r;
  logic cclk_s;
  logic cclk_d_r;
  logic cclk_fall;

  // one synchroniser per pin, generated
  logic [4:0] pins;
  logic [4:0] pins_s;
  assign pins = {chip_select_n, read_strobe_n, write_strobe_n, high_byte_select, conv_clk};
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_sync
      abp_sync u_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .pin_in(pins[gi]),
        .level_out(pins_s[gi])
      );
    end
  endgenerate
  assign strb = abp_pkg::abp_strobe_t'(pins_s[4:1]);
  assign cclk_s = pins_s[0];

  // byte selection shared by the drive path and the checks
  function automatic logic [7:0] sel_byte(input logic [9:0] res, input logic hb);
    sel_byte = hb ? {6'h00, res[9:8]} : res[7:0];
  endfunction : sel_byte

  logic rd_fall;
  logic wr_rise;
  logic cs_fall;
  assign rd_fall = strb_d_r.rd_n && !strb.rd_n && !strb.cs_n;
  // a select that falls onto a strobe already low also opens the read
  assign cs_fall = strb_d_r.cs_n && !strb.cs_n && !strb.rd_n;
  assign wr_rise = !strb_d_r.wr_n && strb.wr_n && !strb.cs_n;
  assign cclk_fall = cclk_d_r && !cclk_s;

  // sequencer state
  abp_pkg::abp_state_t st_r, st_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [7:0] cfg_r, cfg_nxt;
  logic [9:0] res_r, res_nxt;
  logic done_n_r, done_n_nxt;
  logic rd_act_r, rd_act_nxt;
  logic [7:0] dout_r, dout_nxt;
  logic doe_r, doe_nxt;
  logic ioe_r, ioe_nxt;
  logic busy_r, busy_nxt;

  // next-state: config capture, acquisition and conversion timing in conv clock falls
  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    cfg_nxt = cfg_r;
    res_nxt = res_r;
    done_n_nxt = done_n_r;
    if (wr_rise)
    begin
      if (st_r == abp_pkg::ABP_WAIT_EXT)
      begin
        // external mode: second write edge ends acquisition
        st_nxt = abp_pkg::ABP_CONV;
        cnt_nxt = abp_pkg::CONV_CYCLES;
      end
      else
      begin
        cfg_nxt = data_in;
        if (data_in[abp_pkg::CFG_ACQ_EXT_BIT])
        begin
          st_nxt = abp_pkg::ABP_WAIT_EXT;
        end
        else
        begin
          st_nxt = abp_pkg::ABP_ACQ;
          cnt_nxt = abp_pkg::ACQ_CYCLES;
        end
      end
    end
    else
    begin
      unique case (st_r)
        abp_pkg::ABP_IDLE, abp_pkg::ABP_WAIT_EXT:
        begin
          cnt_nxt = cnt_r;
        end
        abp_pkg::ABP_ACQ:
        begin
          // host holds its strobe high past the first fall here
          if (cclk_fall)
          begin
            if (cnt_r == 5'h01)
            begin
              st_nxt = abp_pkg::ABP_CONV;
              cnt_nxt = abp_pkg::CONV_CYCLES;
            end
            else
            begin
              cnt_nxt = cnt_r - 5'h01;
            end
          end
        end
        abp_pkg::ABP_CONV:
        begin
          // time is a fixed number of conv clock periods
          if (cclk_fall)
          begin
            if (cnt_r == 5'h01)
            begin
              st_nxt = abp_pkg::ABP_IDLE;
              res_nxt = core_result;
            end
            else
            begin
              cnt_nxt = cnt_r - 5'h01;
            end
          end
        end
      endcase
    end
    // finishing wins over a read that clears the flag in the same cycle
    if (st_r == abp_pkg::ABP_CONV && st_nxt == abp_pkg::ABP_IDLE)
    begin
      done_n_nxt = 1'b0;
    end
    else if (rd_fall)
    begin
      done_n_nxt = 1'b1;
    end
  end

  // next bus drive: registered so outputs come straight from flops
  always_comb
  begin
    rd_act_nxt = rd_act_r;
    if (rd_fall || cs_fall)
    begin
      rd_act_nxt = 1'b1;
    end
    else if (strb.rd_n || strb.cs_n)
    begin
      rd_act_nxt = 1'b0;
    end
    // drive only with both strobes low, never while writing
    doe_nxt = rd_act_nxt && !strb.cs_n && !strb.rd_n && strb.wr_n;
    dout_nxt = doe_nxt ? sel_byte(res_r, strb.hbsel) : 8'h00;
    ioe_nxt = !strb.cs_n;
    busy_nxt = (st_nxt != abp_pkg::ABP_IDLE);
  end

  // register everything
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      strb_d_r <= 4'hf;
      cclk_d_r <= 1'b0;
      st_r <= abp_pkg::ABP_IDLE;
      cnt_r <= 5'h00;
      cfg_r <= abp_pkg::CFG_RESET;
      res_r <= abp_pkg::RESULT_RESET;
      done_n_r <= 1'b1;
      rd_act_r <= 1'b0;
      dout_r <= 8'h00;
      doe_r <= 1'b0;
      ioe_r <= 1'b0;
      busy_r <= 1'b0;
    end
    else
    begin
      strb_d_r <= strb;
      cclk_d_r <= cclk_s;
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      cfg_r <= cfg_nxt;
      res_r <= res_nxt;
      done_n_r <= done_n_nxt;
      rd_act_r <= rd_act_nxt;
      dout_r <= dout_nxt;
      doe_r <= doe_nxt;
      ioe_r <= ioe_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign data_out = dout_r;
  assign data_oe = doe_r;
  assign conversion_done_n = done_n_r;
  assign conversion_done_oe = ioe_r;
  assign config_byte = cfg_r;
  assign converting = busy_r;

  AST_RD_CLEARS_DONE:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      rd_fall && !(st_r == abp_pkg::ABP_CONV && st_nxt == abp_pkg::ABP_IDLE)
      |=> conversion_done_n)
    else $error("done flag not cleared by read");
  AST_CS_RELEASE:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      strb.cs_n |=> !data_oe)
    else $error("bus still driven after chip select high");
  AST_RD_RELEASE:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      strb.rd_n |=> !data_oe)
    else $error("bus still driven after read strobe high");
  AST_BYTE_SEL:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      data_oe |-> data_out == sel_byte($past(res_r), $past(strb.hbsel)))
    else $error("wrong byte on bus");
  AST_HB_FOLLOW:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      data_oe && $changed(strb.hbsel) && !strb.rd_n && !strb.cs_n
      |=> data_oe && data_out == sel_byte(res_r, $past(strb.hbsel)))
    else $error("byte did not follow select");
  AST_WR_CAPTURE:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      wr_rise && st_r != abp_pkg::ABP_WAIT_EXT |=> config_byte == $past(data_in))
    else $error("config byte not captured");
  AST_CS_HIZ:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      strb.cs_n |=> !conversion_done_oe && !data_oe)
    else $error("outputs driven with chip select high");
  AST_DONE_SET:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      st_r == abp_pkg::ABP_CONV && cclk_fall && cnt_r == 5'h01 && !wr_rise
      |=> !conversion_done_n && st_r == abp_pkg::ABP_IDLE)
    else $error("done not raised at conversion end");
  AST_READ_DRIVE:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      (rd_fall || cs_fall) && strb.wr_n |=> data_oe)
    else $error("read did not drive the bus");
endmodule : abp_host_port

// [testbench/abp_host_model.sv]
// host side model: strobes, write data and a gated conversion clock
`timescale 1ns/1ps
module abp_host_model (
  // clock
  input wire logic ref_clk,
  // host pins
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic hb,
  output logic [7:0] host_d,
  output logic conv_clk
);
  initial
  begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    hb = 1'b0;
    host_d = 8'h5a;
    conv_clk = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  // every driver waits for an edge so pins change at the rising edge
  task automatic pins(input logic cs, input logic rd, input logic h);
    tick(1);
    cs_n <= cs;
    rd_n <= rd;
    hb <= h;
  endtask : pins
  // data stays valid past the rising write edge
  task automatic write_cfg(input logic [7:0] v);
    tick(1);
    host_d <= v;
    wr_n <= 1'b0;
    tick(4);
    wr_n <= 1'b1;
    tick(6);
    host_d <= ~v; // released bus shows the inverse, not a stale byte
  endtask : write_cfg
  // write strobe stays high while the clock runs
  task automatic run_clk(input int n);
    tick(1);
    repeat (n)
    begin
      conv_clk <= 1'b1;
      tick(8);
      conv_clk <= 1'b0;
      tick(8);
    end
  endtask : run_clk
endmodule : abp_host_model

// [testbench/adc_byte_parallel_host_port_bench.sv]
// self-checking bench for the byte-parallel host port
`timescale 1ns/1ps
module adc_byte_parallel_host_port_bench;
  logic ref_clk;
  logic sys_rst;
  logic [9:0] core_result;
  logic [7:0] data_in;
  logic [7:0] data_out;
  logic data_oe;
  logic conversion_done_n;
  logic conversion_done_oe;
  logic [7:0] config_byte;
  logic converting;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic hb;
  logic [7:0] host_d;
  logic conv_clk;
  logic [15:0] lfsr;
  logic [7:0] cfg;
  int num_errors;
  int checked;
  int cycles;
  // resolved bus: design wins while it drives
  assign data_in = data_oe ? data_out : host_d;
  abp_host_model i_abp_host_model (.ref_clk(ref_clk), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .hb(hb), .host_d(host_d), .conv_clk(conv_clk));
  abp_host_port i_abp_host_port (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .chip_select_n(cs_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
    .high_byte_select(hb), .conv_clk(conv_clk), .core_result(core_result),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .conversion_done_n(conversion_done_n), .conversion_done_oe(conversion_done_oe),
    .config_byte(config_byte), .converting(converting));
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  function automatic logic [7:0] exp_byte(input logic [9:0] r, input logic h);
    return h ? {6'h00, r[9:8]} : r[7:0];
  endfunction : exp_byte
  // settle 1 ns past the edge so design updates have landed
  task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
    #1;
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // bounded wait for the bus enable to reach a level
  task automatic wait_oe(input logic v);
    int n;
    n = 0;
    while (data_oe !== v && n < 10)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check("data_oe", {9'h000, v}, {9'h000, data_oe});
  endtask : wait_oe
  // read the byte, flip the byte select mid-read, then end the read
  task automatic do_read(input logic h);
    i_abp_host_model.pins(1'b0, 1'b0, h);
    wait_oe(1'b1);
    check("byte", {2'h0, exp_byte(core_result, h)}, {2'h0, data_out});
    check("done_n", 10'h001, {9'h000, conversion_done_n});
    i_abp_host_model.pins(1'b0, 1'b0, ~h);
    i_abp_host_model.tick(7);
    check("byte", {2'h0, exp_byte(core_result, ~h)}, {2'h0, data_out});
    i_abp_host_model.pins(1'b0, 1'b1, ~h);
    wait_oe(1'b0);
  endtask : do_read
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  // cycle ceiling well above the fewer than two thousand cycles the tests need
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      report_and_stop();
    end
  end
  initial
  begin
    sys_rst = 1'b1;
    core_result = 10'h000;
    lfsr = 16'h0061;
    num_errors = 0;
    checked = 0;
    cycles = 0;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    // strobes with the chip deselected must be ignored
    for (int j = 0; j < 4; j++)
    begin
      lfsr = lfsr_next(lfsr);
      i_abp_host_model.pins(1'b1, lfsr[0], lfsr[1]);
      i_abp_host_model.write_cfg(lfsr[15:8]);
    end
    i_abp_host_model.pins(1'b1, 1'b0, 1'b0);
    i_abp_host_model.tick(8);
    check("oe idle", 10'h000, {8'h00, data_oe, conversion_done_oe});
    check("cfg idle", 10'h000, {1'b0, config_byte, converting});
    i_abp_host_model.pins(1'b0, 1'b0, 1'b0);
    wait_oe(1'b1);
    i_abp_host_model.pins(1'b1, 1'b0, 1'b0);
    wait_oe(1'b0);
    check("done_oe", 10'h000, {9'h000, conversion_done_oe});
    i_abp_host_model.pins(1'b0, 1'b1, 1'b0);
    for (int k = 0; k < 6; k++)
    begin
      @(posedge ref_clk);
      lfsr = lfsr_next(lfsr);
      cfg = {lfsr[7:6], k[0], lfsr[4:0]};
      core_result <= (k == 2) ? 10'h3ff : lfsr[15:6];
      i_abp_host_model.write_cfg(cfg);
      if (k[0])
      begin
        i_abp_host_model.run_clk(3);
        check("wait ext", 10'h003, {8'h00, converting, conversion_done_n});
        i_abp_host_model.write_cfg(cfg);
        i_abp_host_model.run_clk(12);
      end
      else
        i_abp_host_model.run_clk(15);
      check("busy", 10'h003, {8'h00, converting, conversion_done_n});
      i_abp_host_model.run_clk(1);
      check("done", 10'h002, {8'h00, conversion_done_oe, conversion_done_n});
      check("config", {2'h0, cfg}, {2'h0, config_byte});
      do_read(lfsr[3]);
      check("idle", 10'h000, {9'h000, converting});
    end
    report_and_stop();
  end
endmodule : adc_byte_parallel_host_port_bench
